/* File: core/pmcm_consts.svh */
// Constants for the power mode clock manager: field positions, reset values, timing.
`ifndef PMCM_CONSTS_SVH
`define PMCM_CONSTS_SVH
`define PMCM_CTRL_PSM 0
`define PMCM_CTRL_DHF 1
`define PMCM_CTRL_IDLE 2
`define PMCM_CTRL_HALT 3
`define PMCM_CTRL_WB 5
`define PMCM_CTRL_RST 8'h00
`define PMCM_CLK_HZ 50000000
`define PMCM_SLOW_DIV 16'h05f5
`endif

/* File: core/pmcm_pkg.sv */
// Types shared by the power mode clock manager files.
package pmcm_pkg;
   typedef enum logic [1:0] {
      PMCM_ACTIVE = 2'b00,
      PMCM_SAVE = 2'b01,
      PMCM_IDLE = 2'b11,
      PMCM_HALT = 2'b10
   } pmcm_mode_t;
   typedef struct packed {
      logic wr;
      logic power_save_request;
      logic fast_oscillator_disable;
      logic idle;
      logic halt;
      logic wb;
   } pmcm_ctrl_t;
   typedef struct packed {
      logic main_en;
      logic slow_en;
      logic tw_en;
      logic cpu_run;
      logic fast_osc_on;
   } pmcm_gate_t;
endpackage : pmcm_pkg

/* File: core/pmcm_clk_switch.sv */
// Glitch-free handover between main-rate and slow-rate clock enables.
`timescale 1ns/1ps
module pmcm_clk_switch (
   input wire logic sys_clk, // System clock.
   input wire logic resetn, // Asynchronous reset, active low.
   input wire logic want_slow, // Request to run modules at slow rate.
   input wire logic slow_tick, // Slow clock enable pulse.
   input wire logic gate_off, // Stop the module clock entirely.
   output logic main_en, // Module clock enable at main rate.
   output logic slow_en // Module clock enable at slow rate.
);
   logic main_q, main_d; // Main source released.
   logic slow_q, slow_d; // Slow source released.

   // The old source is dropped first; the new one is released only on a slow tick
   // after the other is confirmed off, so no truncated pulse reaches a module.
   always_comb begin
      main_d = main_q;
      slow_d = slow_q;
      if (gate_off || want_slow) begin
         main_d = 1'b0;
      end
      if (gate_off || !want_slow) begin
         slow_d = 1'b0;
      end
      if (!gate_off && want_slow && !main_q && slow_tick) begin
         slow_d = 1'b1;
      end
      if (!gate_off && !want_slow && !slow_q && slow_tick) begin
         main_d = 1'b1;
      end
   end

   // Registers only.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         main_q <= 1'b1;
         slow_q <= 1'b0;
      end else begin
         main_q <= main_d;
         slow_q <= slow_d;
      end
   end

   assign main_en = main_q;
   assign slow_en = slow_q & slow_tick;

   a_never_both: assert property (@(posedge sys_clk) disable iff (!resetn)
      !(main_q && slow_q)) else $error("both clock sources released");
endmodule : pmcm_clk_switch

/* File: core/pmcm_top.sv */
// Power mode clock manager: mode state machine, clock enables and wake-up handling.
`timescale 1ns/1ps
`include "pmcm_consts.svh"
// Overview of operation
// - Reset enters Active, modules on main clock.
// - Wait instruction stalls CPU until interrupt.
// - Power Save runs all modules from slow clock.
// - Save without wait: CPU runs slow; else idles.
// - Fast oscillator off only with crystal slow clock, or in Halt.
// - Idle stops all but mode and timing units.
// - Halt gates every clock, stops fast oscillator.
// - Slow oscillator runs; halt stops slow clock.
// - Timing unit on slow clock except in Halt.
// - Real-time modules use slow rate in Save.
// - Wake-up clears all requests, returns Active.
// - Enter Active only when fast clock stable.
// - Leave for Save/Idle only when slow stable.
// - Deferred entry waits for wait instruction.
module pmcm_top (
   input wire logic sys_clk, // Fast main clock, 50 MHz.
   input wire logic resetn, // Asynchronous reset, active low.
   input pmcm_pkg::pmcm_ctrl_t ctrl, // Software write of the control bits.
   input wire logic wait_exec, // One-cycle pulse: CPU executes the wait instruction.
   input wire logic irq_pending, // Interrupt pending toward the CPU.
   input wire logic wake_event, // Hardware wake-up event, from a pin domain.
   input wire logic fast_clock_stable_in, // Fast oscillator stable, from a pin.
   input wire logic slow_clock_stable_in, // Slow clock stable, from a pin.
   input wire logic slow_from_crystal, // Slow clock comes from its own crystal.
   output logic [7:0] power_mode_control_status, // Readback of control and status.
   output pmcm_pkg::pmcm_mode_t mode, // Current operating mode.
   output pmcm_pkg::pmcm_gate_t gates, // Clock enables and oscillator control.
   output logic slow_system_clock // Slow clock enable pulse, silent in Halt.
);
   import pmcm_pkg::*;

   // Synchronisers for pin-domain inputs.
   logic [1:0] wake_s_q, fs_s_q, ss_s_q; // Two-stage synchronisers.
   logic wake_s, fast_ok, slow_ok; // Synchronised levels.

   // Control bits.
   logic psm_q, psm_d; // Power save request.
   logic dhf_q, dhf_d; // Fast oscillator disable.
   logic idle_q, idle_d; // Idle request.
   logic halt_q, halt_d; // Halt request.
   logic wb_q, wb_d; // Deferred entry control.
   logic wait_q, wait_d; // Wait instruction seen, held until the mode changes or a wake-up.
   logic stall_q, stall_d; // CPU stalled by wait.
   pmcm_mode_t mode_q, mode_d; // Mode state.

   // Slow tick divider.
   logic [15:0] div_q, div_d; // Divider count.
   logic tick; // Raw slow tick, always running with the oscillator.

   // Gate-level outputs of the clock switch.
   logic main_en, slow_en; // Module clock enables.

   // Register the pin inputs twice before any use.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wake_s_q <= 2'b00;
         fs_s_q <= 2'b00;
         ss_s_q <= 2'b00;
      end else begin
         wake_s_q <= {wake_s_q[0], wake_event};
         fs_s_q <= {fs_s_q[0], fast_clock_stable_in};
         ss_s_q <= {ss_s_q[0], slow_clock_stable_in};
      end
   end
   assign wake_s = wake_s_q[1];
   assign fast_ok = fs_s_q[1];
   assign slow_ok = ss_s_q[1];

   // Divider for the slow oscillator rate; the oscillator itself never stops.
   always_comb begin
      div_d = div_q + 16'h0001;
      if (div_q == `PMCM_SLOW_DIV) begin
         div_d = 16'h0000;
      end
   end
   assign tick = (div_q == `PMCM_SLOW_DIV);

   // Internal slow system clock is silent while halted.
   assign slow_system_clock = tick && (mode_q != PMCM_HALT);

   // Next control bits: software writes, then wake-up clears win over writes.
   always_comb begin
      psm_d = psm_q;
      dhf_d = dhf_q;
      idle_d = idle_q;
      halt_d = halt_q;
      wb_d = wb_q;
      wait_d = wait_q;
      stall_d = stall_q;
      if (ctrl.wr) begin
         dhf_d = ctrl.fast_oscillator_disable && slow_from_crystal;
         idle_d = ctrl.idle;
         halt_d = ctrl.halt;
         wb_d = ctrl.wb;
         // Deferred entry shows the bit at once; immediate entry shows it on arrival.
         psm_d = ctrl.power_save_request && (ctrl.wb || mode_q != PMCM_ACTIVE);
      end
      if (mode_d == PMCM_SAVE && mode_q == PMCM_ACTIVE) begin
         psm_d = 1'b1;
      end
      if (wait_exec) begin
         wait_d = 1'b1;
         stall_d = 1'b1;
      end
      if (irq_pending) begin
         stall_d = 1'b0;
      end
      if (mode_q != mode_d) begin
         wait_d = 1'b0;
      end
      if (wake_s) begin
         psm_d = 1'b0;
         dhf_d = 1'b0;
         idle_d = 1'b0;
         halt_d = 1'b0;
         wait_d = 1'b0;
      end
   end

   // Immediate entry request held until the switch completes.
   logic pend_q, pend_d; // Immediate power save pending.
   always_comb begin
      pend_d = pend_q;
      if (ctrl.wr && ctrl.power_save_request && !ctrl.wb && mode_q == PMCM_ACTIVE) begin
         pend_d = 1'b1;
      end
      if (mode_q == PMCM_SAVE || wake_s || (ctrl.wr && !ctrl.power_save_request)) begin
         pend_d = 1'b0;
      end
   end

   // Mode state machine. Halt leaves on the wake event directly without waiting
   // for a slow tick; elsewhere steps take effect on slow ticks.
   always_comb begin
      mode_d = mode_q;
      unique case (mode_q)
         PMCM_ACTIVE: begin
            if (tick && wait_q && wb_q && halt_q) begin
               mode_d = PMCM_HALT;
            end else if (tick && slow_ok && wait_q && wb_q && idle_q) begin
               mode_d = PMCM_IDLE;
            end else if (tick && slow_ok && pend_q) begin
               mode_d = PMCM_SAVE;
            end else if (tick && slow_ok && wait_q && wb_q && psm_q) begin
               mode_d = PMCM_SAVE;
            end
         end
         PMCM_SAVE: begin
            if (tick && !psm_q && fast_ok) begin
               mode_d = PMCM_ACTIVE;
            end else if (tick && wait_q && halt_q) begin
               mode_d = PMCM_HALT;
            end else if (tick && wait_q && idle_q) begin
               mode_d = PMCM_IDLE;
            end
         end
         PMCM_IDLE: begin
            if (tick && !idle_q && fast_ok) begin
               mode_d = PMCM_ACTIVE;
            end else if (tick && wait_q && halt_q) begin
               mode_d = PMCM_HALT;
            end
         end
         PMCM_HALT: begin
            if (!halt_q && fast_ok) begin
               mode_d = PMCM_ACTIVE;
            end
         end
      endcase
   end

   // Register all control state; reset lands in Active.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         mode_q <= PMCM_ACTIVE;
         psm_q <= 1'b0;
         dhf_q <= 1'b0;
         idle_q <= 1'b0;
         halt_q <= 1'b0;
         wb_q <= 1'b0;
         wait_q <= 1'b0;
         stall_q <= 1'b0;
         pend_q <= 1'b0;
         div_q <= 16'h0000;
      end else begin
         mode_q <= mode_d;
         psm_q <= psm_d;
         dhf_q <= dhf_d;
         idle_q <= idle_d;
         halt_q <= halt_d;
         wb_q <= wb_d;
         wait_q <= wait_d;
         stall_q <= stall_d;
         pend_q <= pend_d;
         div_q <= div_d;
      end
   end

   // Clock source switch; Save uses slow rate for every module including
   // baud generators, converters and timers, which software must rescale.
   // The switch follows the next mode so that its enables drop on the same
   // edge as the mode changes; otherwise one stray main cycle would leak.
   pmcm_clk_switch u_switch (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .want_slow(mode_d == PMCM_SAVE),
      .slow_tick(tick),
      .gate_off(mode_d == PMCM_IDLE || mode_d == PMCM_HALT),
      .main_en(main_en),
      .slow_en(slow_en)
   );

   // Output gates. Stall blocks CPU only; clocks of the mode keep running.
   always_comb begin
      gates.main_en = main_en;
      gates.slow_en = slow_en;
      gates.tw_en = slow_system_clock;
      gates.cpu_run = (main_en || slow_en) && !stall_q;
      gates.fast_osc_on = (mode_q == PMCM_ACTIVE) ||
         ((mode_q == PMCM_SAVE || mode_q == PMCM_IDLE) && !dhf_q);
   end

   assign mode = mode_q;
   assign power_mode_control_status = {slow_ok, fast_ok, wb_q, 1'b0,
      halt_q, idle_q, dhf_q, psm_q};

   a_halt_silent: assert property (@(posedge sys_clk) disable iff (!resetn)
      mode_q == PMCM_HALT |-> !gates.tw_en && !gates.fast_osc_on && !gates.main_en
      && !gates.slow_en) else $error("clock active in halt");
   a_idle_gated: assert property (@(posedge sys_clk) disable iff (!resetn)
      mode_q == PMCM_IDLE |-> !gates.main_en && !gates.slow_en
      && (gates.tw_en == tick)) else $error("idle gating wrong");
   a_wake_clears: assert property (@(posedge sys_clk) disable iff (!resetn)
      wake_s |=> !psm_q && !idle_q && !halt_q && !dhf_q) else $error("wake kept");
   a_active_fast: assert property (@(posedge sys_clk) disable iff (!resetn)
      mode_q != PMCM_ACTIVE ##1 mode_q == PMCM_ACTIVE |-> $past(fast_ok))
      else $error("active without fast clock");
   a_leave_slow: assert property (@(posedge sys_clk) disable iff (!resetn)
      $past(mode_q) == PMCM_ACTIVE && (mode_q == PMCM_SAVE || mode_q == PMCM_IDLE)
      |-> $past(slow_ok)) else $error("left active without slow clock");
   a_defer_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
      mode_q == PMCM_ACTIVE && wb_q && !wait_q && !pend_q |=> mode_q != PMCM_SAVE)
      else $error("deferred entry too early");
   a_dhf_crystal: assert property (@(posedge sys_clk) disable iff (!resetn)
      ctrl.wr && ctrl.fast_oscillator_disable && !slow_from_crystal && !wake_s |=> !dhf_q)
      else $error("oscillator disabled without crystal");
   a_stall_wait: assert property (@(posedge sys_clk) disable iff (!resetn)
      wait_exec && !irq_pending |=> !gates.cpu_run [*2])
      else $error("cpu ran during wait");
   a_save_slow: assert property (@(posedge sys_clk) disable iff (!resetn)
      mode_q == PMCM_SAVE |-> !gates.main_en) else $error("main clock in save");
   c_enter_save: cover property (@(posedge sys_clk) mode_q == PMCM_SAVE);
   c_enter_idle: cover property (@(posedge sys_clk) mode_q == PMCM_IDLE);
   c_enter_halt: cover property (@(posedge sys_clk) mode_q == PMCM_HALT);
   c_wake_back: cover property (@(posedge sys_clk)
      mode_q == PMCM_HALT ##[1:20] mode_q == PMCM_ACTIVE);
endmodule : pmcm_top

/* File: sim/pmcm_cpu_model.sv */
// Behavioural CPU and peripheral side that counts the clock enables it is given.
`timescale 1ns/1ps
module pmcm_cpu_model (
   input wire logic sys_clk, // System clock.
   input wire logic clr, // Restart every count.
   input pmcm_pkg::pmcm_gate_t gates, // Enables from the manager.
   input wire logic tick, // Slow system clock pulse.
   output logic [15:0] main_cnt, // Cycles clocked at main rate.
   output logic [15:0] slow_cnt, // Slow-rate module clocks.
   output logic [15:0] tw_cnt, // Timing unit clocks.
   output logic [15:0] tick_cnt, // Slow system clock pulses.
   output logic [15:0] cpu_cnt // Cycles in which the CPU may run.
);
   import pmcm_pkg::*;
   // Counts are 16 bits, wide enough for the longest window the bench opens.
   always_ff @(posedge sys_clk) begin
      if (clr) begin
         main_cnt <= 16'h0000;
         slow_cnt <= 16'h0000;
         tw_cnt <= 16'h0000;
         tick_cnt <= 16'h0000;
         cpu_cnt <= 16'h0000;
      end else begin
         main_cnt <= main_cnt + {15'h0000, gates.main_en};
         slow_cnt <= slow_cnt + {15'h0000, gates.slow_en};
         tw_cnt <= tw_cnt + {15'h0000, gates.tw_en};
         tick_cnt <= tick_cnt + {15'h0000, tick};
         cpu_cnt <= cpu_cnt + {15'h0000, gates.cpu_run};
      end
   end
endmodule : pmcm_cpu_model

/* File: sim/tb_top.sv */
// Self-checking bench for the power mode clock manager.
`timescale 1ns/1ps
module tb_top;
   import pmcm_pkg::*;
   logic sys_clk = 1'b0; // Main clock, 20 ns period.
   logic resetn = 1'b0; // Reset, active low.
   pmcm_ctrl_t ctrl = '0; // Control write bundle.
   logic wait_exec = 1'b0; // Wait instruction pulse.
   logic irq_pending = 1'b0; // Interrupt toward the CPU.
   logic wake_event = 1'b0; // Hardware wake-up.
   logic fast_ok = 1'b1; // Fast clock stable.
   logic slow_ok = 1'b1; // Slow clock stable.
   logic xtal = 1'b0; // Slow clock from its crystal.
   logic clr = 1'b0; // Restart model counts.
   logic [7:0] status; // Control and status readback.
   pmcm_mode_t mode; // Current mode.
   pmcm_gate_t gates; // Enables.
   logic ssc; // Slow system clock pulse.
   logic [15:0] main_cnt, slow_cnt, tw_cnt, tick_cnt; // Model counts.
   logic [15:0] cpu_cnt; // CPU cycles counted by the model.
   int bad_count = 0; // Mismatches.
   int total_checks = 0; // Comparisons.
   int cycles = 0; // Run length guard.
   int mk; // Kind taken off the queue.
   logic [7:0] me; // Expected value taken off the queue.
   logic [31:0] seed = 32'h9394; // Random state.
   int kind_q[$]; // Kinds of pending notes.
   logic [7:0] exp_q[$]; // Expected values of pending notes.
   event look; // A result is ready to be looked at.
   always #10 sys_clk = ~sys_clk;
   pmcm_top dut_u (.sys_clk(sys_clk), .resetn(resetn), .ctrl(ctrl), .wait_exec(wait_exec),
      .irq_pending(irq_pending), .wake_event(wake_event), .fast_clock_stable_in(fast_ok),
      .slow_clock_stable_in(slow_ok), .slow_from_crystal(xtal),
      .power_mode_control_status(status), .mode(mode), .gates(gates), .slow_system_clock(ssc));
   pmcm_cpu_model model_u (.sys_clk(sys_clk), .clr(clr), .gates(gates), .tick(ssc),
      .main_cnt(main_cnt), .slow_cnt(slow_cnt), .tw_cnt(tw_cnt), .tick_cnt(tick_cnt),
      .cpu_cnt(cpu_cnt));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // Status as it should read, with the stable flags as currently driven.
   function automatic logic [7:0] st(input logic w, input logic [3:0] low);
      return {slow_ok, fast_ok, w, 1'b0, low};
   endfunction : st
   task automatic summarize();
      $display("checks %0d, mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : summarize
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : cyc
   task automatic note(input int k, input logic [7:0] e);
      kind_q.push_back(k);
      exp_q.push_back(e);
      -> look;
   endtask : note
   task automatic wr(input logic p, input logic d, input logic i, input logic h, input logic w);
      ctrl = '{1'b1, p, d, i, h, w};
      cyc(1);
      ctrl.wr = 1'b0;
   endtask : wr
   task automatic pulse();
      wait_exec = 1'b1;
      cyc(1);
      wait_exec = 1'b0;
   endtask : pulse
   // Bounded wait: a mode never reached shows up in the following mode check.
   task automatic wait_mode(input pmcm_mode_t m);
      int n;
      n = 0;
      while (mode !== m && n < 3200) begin
         cyc(1);
         n++;
      end
      cyc(1);
   endtask : wait_mode
   task automatic win(input int n);
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
      cyc(n);
   endtask : win
   task automatic wake();
      wake_event = 1'b1;
      cyc(6);
      wake_event = 1'b0;
   endtask : wake
   task automatic report(input string nm, input logic [7:0] e, input logic [7:0] o);
      total_checks++;
      if (o !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, o);
      end
   endtask : report
   task automatic chk_mode(input logic [1:0] e);
      report("mode", {6'h00, e}, {6'h00, mode});
   endtask : chk_mode
   task automatic chk_vec(input string nm, input logic [7:0] e, input logic [7:0] o);
      report(nm, e, o);
   endtask : chk_vec
   task automatic chk_cnt(input int k, input logic e);
      logic [15:0] c;
      c = (k == 3) ? main_cnt : (k == 4) ? slow_cnt : (k == 5) ? tw_cnt :
         (k == 7) ? cpu_cnt : tick_cnt;
      report("activity", {7'h00, e}, {7'h00, |c});
   endtask : chk_cnt
   // Watcher: each note is compared against the outputs as they stand now.
   always begin
      @(look);
      while (kind_q.size() > 0) begin
         mk = kind_q.pop_front();
         me = exp_q.pop_front();
         case (mk)
            0: chk_mode(me[1:0]);
            1: chk_vec("status", me, status);
            2: chk_vec("gates", me, {3'h0, gates & 5'h13});
            default: chk_cnt(mk, me[0]);
         endcase
      end
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 60000) begin
         bad_count++;
         summarize();
      end
   end
   initial begin
      cyc(2);
      resetn = 1'b1;
      cyc(3);
      note(0, PMCM_ACTIVE);
      note(2, 8'h13);
      note(1, st(1'b0, 4'h0));
      wr(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
      cyc(1);
      note(1, st(1'b0, 4'h0));
      xtal = 1'b1;
      wr(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
      cyc(1);
      note(1, st(1'b0, 4'h2));
      note(2, 8'h13);
      wr(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
      cyc(1);
      note(1, st(1'b0, 4'h2));
      wait_mode(PMCM_SAVE);
      note(0, PMCM_SAVE);
      note(1, st(1'b0, 4'h3));
      // Between slow ticks the CPU enable is low and the fast oscillator is off.
      note(2, 8'h00);
      win(3200);
      note(3, 8'h00);
      note(4, 8'h01);
      note(5, 8'h01);
      note(7, 8'h01);
      wake();
      note(1, st(1'b0, 4'h0));
      wait_mode(PMCM_ACTIVE);
      note(0, PMCM_ACTIVE);
      slow_ok = 1'b0;
      cyc(3);
      wr(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      win(3200);
      note(0, PMCM_ACTIVE);
      note(3, 8'h01);
      wake();
      slow_ok = 1'b1;
      cyc(3);
      wr(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
      cyc(1);
      note(1, st(1'b1, 4'h1));
      win(1600);
      note(0, PMCM_ACTIVE);
      seed = lfsr(seed);
      cyc(int'(seed[2:0]) + 1);
      pulse();
      cyc(2);
      note(2, 8'h11);
      wait_mode(PMCM_SAVE);
      note(0, PMCM_SAVE);
      note(2, 8'h01);
      win(3200);
      note(7, 8'h00);
      irq_pending = 1'b1;
      cyc(2);
      // Released, but the CPU only gets slow-tick enables in Power Save.
      note(2, 8'h01);
      irq_pending = 1'b0;
      win(3200);
      note(7, 8'h01);
      wr(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
      cyc(1);
      pulse();
      wait_mode(PMCM_IDLE);
      note(0, PMCM_IDLE);
      win(3200);
      note(3, 8'h00);
      note(4, 8'h00);
      note(5, 8'h01);
      note(6, 8'h01);
      wake();
      wait_mode(PMCM_ACTIVE);
      slow_ok = 1'b0;
      cyc(3);
      wr(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
      cyc(1);
      pulse();
      wait_mode(PMCM_HALT);
      note(0, PMCM_HALT);
      note(2, 8'h00);
      win(3200);
      note(3, 8'h00);
      note(5, 8'h00);
      note(6, 8'h00);
      fast_ok = 1'b0;
      slow_ok = 1'b1;
      wake();
      win(1600);
      note(0, PMCM_HALT);
      fast_ok = 1'b1;
      wait_mode(PMCM_ACTIVE);
      note(0, PMCM_ACTIVE);
      #1;
      summarize();
   end
endmodule : tb_top
